// >>> ssc_pkg.sv
// Constants, codes and register map of the signed snapshot control block.
package ssc_pkg;
	// Clock and coordination timing.
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned FB_WAIT_US      = 1000;
	localparam int unsigned FB_WAIT_CYC_DEF = (FB_WAIT_US * 1000) / CLK_PERIOD_NS;

	// Register word addresses.
	localparam logic [15:0] ADDR_KEY_AREA = 16'h9e02;
	localparam logic [15:0] ADDR_KEY_LEN  = 16'h9e03;
	localparam logic [15:0] ADDR_KEY_DATA = 16'h9e04;
	localparam logic [15:0] ADDR_CUR_STAT = 16'h9e4d;
	localparam logic [15:0] ADDR_ON_STAT  = 16'h9f4b;
	localparam logic [15:0] ADDR_SIG_AREA = 16'ha014;
	localparam logic [15:0] ADDR_SIG_LEN  = 16'ha015;
	localparam logic [15:0] ADDR_SIG_DATA = 16'ha016;
	localparam logic [15:0] ADDR_OFF_STAT = 16'ha049;
	localparam logic [15:0] AREA_WORDS    = 16'h0030;

	// Key and signature store layout.
	localparam int          MEM_AW   = 7;
	localparam logic [6:0]  KEY_BASE = 7'h00;
	localparam logic [6:0]  SIG_BASE = 7'h40;

	// Snapshot status codes.
	typedef enum logic [2:0] {
		ST_VALID         = 3'h0,
		ST_INVALID       = 3'h1,
		ST_UPDATING      = 3'h2,
		ST_FAIL_GENERAL  = 3'h3,
		ST_FAIL_RELEASE  = 3'h4,
		ST_FAIL_CONTACT  = 3'h5
	} ssc_status_t;
	localparam logic [15:0] STATUS_UPDATE = 16'h0002;

	// Snapshot kinds, equal to the hashed type field.
	typedef enum logic [2:0] {
		KIND_CURRENT = 3'h0,
		KIND_TURN_ON = 3'h1,
		KIND_TURN_OFF = 3'h2,
		KIND_START   = 3'h3,
		KIND_END     = 3'h4
	} ssc_kind_t;

	// Sequencer states, one bit apart from S_IDLE through S_FB, S_CAPT and S_STREAM to S_SIGN.
	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_FB     = 3'h1,
		S_CAPT   = 3'h3,
		S_STREAM = 3'h2,
		S_SIGN   = 3'h6
	} ssc_state_t;

	// Hashed record layout.
	localparam int          NUM_FIELDS  = 22;
	localparam int          NUM_VALUES  = 16;
	localparam logic [4:0]  LAST_FIELD  = 5'h15;
	localparam int          F_TYPE      = 0;
	localparam int          F_RESPONSE_COUNTER      = 4;
	localparam logic [4:0]  F_ADDR_TEXT = 5'h03;
	localparam logic [4:0]  F_META_BASE = 5'h11;
	localparam logic [21:0] FIELD_TEXT  = 22'h1c0008;
	localparam logic [7:0]  SCALE_DEF   = 8'h00;
	localparam logic [8:0]  NUM_LAST    = 9'h005;
	localparam logic [8:0]  TEXT_HDR    = 9'h003;
	localparam int FIELD_SRC [0:NUM_FIELDS-1] = '{0, 0, 1, 0, 0, 2, 3, 4, 5, 6, 7, 8,
		9, 10, 11, 12, 13, 14, 0, 0, 0, 15};
	localparam logic [7:0] FIELD_UNIT [0:NUM_FIELDS-1] = '{8'hff, 8'h1e, 8'h1b, 8'h00,
		8'hff, 8'h07, 8'h07, 8'h06, 8'hff, 8'h07, 8'hff, 8'hff, 8'h07, 8'h07, 8'h06,
		8'h07, 8'h07, 8'h06, 8'h00, 8'h00, 8'h00, 8'hff};

	// Meter event word.
	localparam int EVT_VALUE_IDX = 15;
	localparam int EVT_FAULT_LSB = 16;
	localparam int EVT_FAULT_W   = 4;

	// Hash byte FIFO.
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 16;
endpackage

// >>> ssc_word_mem.sv
// Word store for the public key and signature areas, registered read.
`timescale 1ns/1ps
module ssc_word_mem #(
	parameter int AW = 7,
	parameter int DW = 16
) (
	// Clock and reset
	input  wire logic          clk_in,
	input  wire logic          srst_in,
	// Write port
	input  wire logic          wr_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [DW-1:0] wdata_in,
	// Read port
	input  wire logic [AW-1:0] raddr_in,
	output logic      [DW-1:0] rdata_out
);
	logic [DW-1:0] mem_reg [0:(1<<AW)-1];

	always_ff @(posedge clk_in) begin
		if (wr_in) begin
			mem_reg[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= mem_reg[raddr_in];
		end
	end
endmodule

// >>> ssc_byte_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ssc_byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             srst_in,
	// Filling side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// Draining side
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] buf_reg [0:DEPTH-1];
	logic [PW:0]      wptr_reg;
	logic [PW:0]      rptr_reg;

	wire full  = (wptr_reg[PW] != rptr_reg[PW]) && (wptr_reg[PW-1:0] == rptr_reg[PW-1:0]);
	wire empty = (wptr_reg == rptr_reg);
	wire push  = in_valid_in && !full;
	wire pop   = out_ready_in && !empty;

	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = buf_reg[rptr_reg[PW-1:0]];

	always_ff @(posedge clk_in) begin
		if (push) begin
			buf_reg[wptr_reg[PW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			wptr_reg <= wptr_reg + (PW+1)'(push);
			rptr_reg <= rptr_reg + (PW+1)'(pop);
		end
	end
endmodule

// >>> ssc_snapshot_ctrl.sv
// Signed snapshot control: status registers, coordination, record serialiser.
`timescale 1ns/1ps
module ssc_snapshot_ctrl
	import ssc_pkg::*;
#(
	parameter int unsigned FB_WAIT_CYC = FB_WAIT_CYC_DEF
) (
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     srst_in,
	// Register port, word addressed
	input  wire logic [15:0]              reg_addr_in,
	input  wire logic [15:0]              reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic      [15:0]              reg_rdata_out,
	output logic                          reg_rvalid_out,
	// Live meter values and text fetch
	input  wire logic [NUM_VALUES*32-1:0] meter_values_in,
	output logic      [1:0]               text_sel_out,
	output logic      [7:0]               text_idx_out,
	input  wire logic [7:0]               text_len_in,
	input  wire logic [7:0]               text_byte_in,
	// Hash byte stream
	output logic      [7:0]               hash_byte_out,
	output logic                          hash_last_out,
	output logic                          hash_valid_out,
	input  wire logic                     hash_ready_in,
	// Signing engine
	output logic                          sign_start_out,
	input  wire logic                     sign_done_in,
	input  wire logic                     sign_err_in,
	input  wire logic [15:0]              sig_len_in,
	input  wire logic [15:0]              key_len_in,
	input  wire logic                     store_wr_in,
	input  wire logic [MEM_AW-1:0]        store_addr_in,
	input  wire logic [15:0]              store_data_in,
	// Switch coordination pins
	input  wire logic                     charge_release_input_in,
	input  wire logic                     contactor_fb_in,
	output logic                          contactor_close_out,
	// Device state
	output logic                          not_ready_out,
	output logic      [EVT_FAULT_W-1:0]   fault_flags_out,
	output logic                          busy_out
);
	ssc_state_t  state_reg, state_next;
	ssc_kind_t   kind_reg, kind_next;
	ssc_status_t stat_reg [0:2];
	ssc_status_t fin_code;
	logic        fin_valid;
	logic [31:0] cnt_reg, cnt_next;
	logic [4:0]  fidx_reg, fidx_next;
	logic [8:0]  bidx_reg, bidx_next;
	logic        contact_reg, contact_next;
	logic        cap_load;
	logic        push;
	logic        start_next;
	logic        sign_ok;
	logic [31:0] response_counter_reg;
	logic [15:0] sig_len_reg;
	logic [31:0] cap_reg [0:NUM_FIELDS-1];
	logic [31:0] cap_src [0:NUM_FIELDS-1];
	logic        release_meta_reg, release_sync_reg;
	logic        fb_meta_reg, fb_sync_reg;
	logic        rd1_reg, rsel_reg;
	logic [15:0] rscal_reg;
	logic [15:0] mem_rdata;
	logic        fifo_ready;
	logic [8:0]  fifo_out;

	// Pin synchronisers; only the second stage is read by logic.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			release_meta_reg <= 1'b0;
			release_sync_reg <= 1'b0;
			fb_meta_reg      <= 1'b0;
			fb_sync_reg      <= 1'b0;
		end else begin
			release_meta_reg <= charge_release_input_in;
			release_sync_reg <= release_meta_reg;
			fb_meta_reg      <= contactor_fb_in;
			fb_sync_reg      <= fb_meta_reg;
		end
	end

	// Update requests; only the value 2 is a request.
	wire wr_upd   = reg_wr_in && (reg_wdata_in == STATUS_UPDATE);
	wire trig_cur = wr_upd && (reg_addr_in == ADDR_CUR_STAT);
	wire trig_on  = wr_upd && (reg_addr_in == ADDR_ON_STAT);
	wire trig_off = wr_upd && (reg_addr_in == ADDR_OFF_STAT);
	wire trig_any = (state_reg == S_IDLE) && (trig_cur || trig_on || trig_off);
	wire ssc_kind_t trig_kind = trig_on ? KIND_TURN_ON :
		(trig_off ? KIND_TURN_OFF : KIND_CURRENT);
	wire ssc_kind_t fin_kind = (state_reg == S_IDLE) ? trig_kind : kind_reg;

	// Serialiser byte selection.
	wire        is_text   = FIELD_TEXT[fidx_reg];
	wire [47:0] num_word  = {cap_reg[fidx_reg], SCALE_DEF, FIELD_UNIT[fidx_reg]};
	wire [5:0]  num_shift = {3'h5 - bidx_reg[2:0], 3'h0};
	wire [47:0] num_sh    = num_word >> num_shift;
	wire [31:0] len_word  = {24'h000000, text_len_in};
	wire [4:0]  len_shift = {2'h3 - bidx_reg[1:0], 3'h0};
	wire [31:0] len_sh    = len_word >> len_shift;
	wire        in_hdr    = (bidx_reg <= TEXT_HDR);
	wire [7:0]  text_b    = in_hdr ? len_sh[7:0] : text_byte_in;
	wire [7:0]  out_byte  = is_text ? text_b : num_sh[7:0];
	wire [8:0]  text_end  = {1'b0, text_len_in} + TEXT_HDR;
	wire        field_end = is_text ? (bidx_reg == text_end) : (bidx_reg == NUM_LAST);
	wire        rec_end   = field_end && (fidx_reg == LAST_FIELD);
	wire [8:0]  text_off  = bidx_reg - 9'h004;

	assign text_sel_out = (fidx_reg == F_ADDR_TEXT) ? 2'h0 : 2'(fidx_reg - F_META_BASE);
	assign text_idx_out = text_off[7:0];

	// Sequencer.
	always_comb begin
		state_next   = state_reg;
		kind_next    = kind_reg;
		cnt_next     = cnt_reg;
		fidx_next    = fidx_reg;
		bidx_next    = bidx_reg;
		contact_next = contact_reg;
		fin_valid    = 1'b0;
		fin_code     = ST_VALID;
		cap_load     = 1'b0;
		push         = 1'b0;
		start_next   = 1'b0;
		sign_ok      = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (trig_any) begin
					kind_next = trig_kind;
					cnt_next  = '0;
					if (trig_kind == KIND_TURN_ON) begin
						if (!release_sync_reg) begin
							fin_valid = 1'b1;
							fin_code  = ST_FAIL_RELEASE;
						end else begin
							contact_next = 1'b1;
							state_next   = S_FB;
						end
					end else if (trig_kind == KIND_TURN_OFF) begin
						contact_next = 1'b0;
						state_next   = S_FB;
					end else begin
						state_next = S_CAPT;
					end
				end
			end
			S_FB: begin
				if (fb_sync_reg == contact_reg) begin
					state_next = S_CAPT;
				end else if (cnt_reg == 32'(FB_WAIT_CYC - 1)) begin
					contact_next = 1'b0;
					fin_valid    = 1'b1;
					fin_code     = ST_FAIL_CONTACT;
					state_next   = S_IDLE;
				end else begin
					cnt_next = cnt_reg + 32'h00000001;
				end
			end
			S_CAPT: begin
				cap_load   = 1'b1;
				fidx_next  = '0;
				bidx_next  = '0;
				state_next = S_STREAM;
			end
			S_STREAM: begin
				push = 1'b1;
				if (fifo_ready) begin
					if (rec_end) begin
						start_next = 1'b1;
						state_next = S_SIGN;
					end else if (field_end) begin
						fidx_next = fidx_reg + 5'h01;
						bidx_next = '0;
					end else begin
						bidx_next = bidx_reg + 9'h001;
					end
				end
			end
			S_SIGN: begin
				if (sign_err_in) begin
					fin_valid  = 1'b1;
					fin_code   = ST_FAIL_GENERAL;
					state_next = S_IDLE;
				end else if (sign_done_in) begin
					sign_ok    = 1'b1;
					fin_valid  = 1'b1;
					fin_code   = ST_VALID;
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg      <= S_IDLE;
			kind_reg       <= KIND_CURRENT;
			cnt_reg        <= '0;
			fidx_reg       <= '0;
			bidx_reg       <= '0;
			contact_reg    <= 1'b0;
			sign_start_out <= 1'b0;
		end else begin
			state_reg      <= state_next;
			kind_reg       <= kind_next;
			cnt_reg        <= cnt_next;
			fidx_reg       <= fidx_next;
			bidx_reg       <= bidx_next;
			contact_reg    <= contact_next;
			sign_start_out <= start_next;
		end
	end

	assign contactor_close_out = contact_reg;
	assign busy_out            = (state_reg != S_IDLE);

	// Status registers; a finishing result beats a fresh request on the same block.
	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_stat
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					stat_reg[k] <= ST_INVALID;
				end else if (fin_valid && (fin_kind == ssc_kind_t'(k))) begin
					stat_reg[k] <= fin_code;
				end else if (trig_any && (trig_kind == ssc_kind_t'(k))) begin
					stat_reg[k] <= ST_UPDATING;
				end
			end
		end
	endgenerate

	// Response counter of every capture and signature length of the last good snapshot.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			response_counter_reg    <= '0;
			sig_len_reg <= '0;
		end else begin
			if (cap_load) begin
				response_counter_reg <= response_counter_reg + 32'h00000001;
			end
			if (sign_ok) begin
				sig_len_reg <= sig_len_in;
			end
		end
	end

	// Captured record; held until the next capture so the hash input is stable.
	genvar f;
	generate
		for (f = 0; f < NUM_FIELDS; f++) begin : g_cap
			if (f == F_TYPE) begin : g_type
				assign cap_src[f] = {29'h00000000, kind_reg};
			end else if (f == F_RESPONSE_COUNTER) begin : g_response_counter
				assign cap_src[f] = response_counter_reg + 32'h00000001;
			end else if (FIELD_TEXT[f]) begin : g_text
				assign cap_src[f] = '0;
			end else begin : g_val
				assign cap_src[f] = meter_values_in[FIELD_SRC[f]*32 +: 32];
			end
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					cap_reg[f] <= '0;
				end else if (cap_load) begin
					cap_reg[f] <= cap_src[f];
				end
			end
		end
	endgenerate

	// Hash stream buffer; a stalled hash engine holds the serialiser.
	ssc_byte_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.srst_in       (srst_in),
		.in_valid_in   (push),
		.in_data_in    ({rec_end, out_byte}),
		.in_ready_out  (fifo_ready),
		.out_valid_out (hash_valid_out),
		.out_data_out  (fifo_out),
		.out_ready_in  (hash_ready_in)
	);

	assign hash_byte_out = fifo_out[7:0];
	assign hash_last_out = fifo_out[8];

	// Register read decode.
	wire [15:0] key_off = reg_addr_in - ADDR_KEY_DATA;
	wire [15:0] sig_off = reg_addr_in - ADDR_SIG_DATA;
	wire        hit_key = (key_off < AREA_WORDS);
	wire        hit_sig = (sig_off < AREA_WORDS);
	wire [MEM_AW-1:0] mem_raddr = hit_key ? (KEY_BASE + key_off[MEM_AW-1:0]) :
		(SIG_BASE + sig_off[MEM_AW-1:0]);
	wire [15:0] scal_val =
		(reg_addr_in == ADDR_KEY_AREA) ? AREA_WORDS :
		(reg_addr_in == ADDR_KEY_LEN)  ? key_len_in :
		(reg_addr_in == ADDR_SIG_AREA) ? AREA_WORDS :
		(reg_addr_in == ADDR_SIG_LEN)  ? sig_len_reg :
		(reg_addr_in == ADDR_CUR_STAT) ? {13'h0000, stat_reg[0]} :
		(reg_addr_in == ADDR_ON_STAT)  ? {13'h0000, stat_reg[1]} :
		(reg_addr_in == ADDR_OFF_STAT) ? {13'h0000, stat_reg[2]} : 16'h0000;

	// Key and signature words as written by the signing engine, big-endian DER.
	ssc_word_mem #(
		.AW (MEM_AW),
		.DW (16)
	) u_mem (
		.clk_in    (clk_in),
		.srst_in   (srst_in),
		.wr_in     (store_wr_in),
		.waddr_in  (store_addr_in),
		.wdata_in  (store_data_in),
		.raddr_in  (mem_raddr),
		.rdata_out (mem_rdata)
	);

	// Two-stage read pipeline so memory and scalar reads share one latency.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd1_reg        <= 1'b0;
			rsel_reg       <= 1'b0;
			rscal_reg      <= '0;
			reg_rvalid_out <= 1'b0;
			reg_rdata_out  <= '0;
		end else begin
			rd1_reg        <= reg_rd_in;
			rsel_reg       <= hit_key || hit_sig;
			rscal_reg      <= scal_val;
			reg_rvalid_out <= rd1_reg;
			reg_rdata_out  <= rsel_reg ? mem_rdata : rscal_reg;
		end
	end

	// Device readiness from the live event word.
	wire [31:0] evt_word = meter_values_in[EVT_VALUE_IDX*32 +: 32];

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			not_ready_out   <= 1'b0;
			fault_flags_out <= '0;
		end else begin
			not_ready_out   <= |evt_word;
			fault_flags_out <= evt_word[EVT_FAULT_LSB +: EVT_FAULT_W];
		end
	end
endmodule

// >>> ssc_snapshot_ctrl_assertions.sv
// Concurrent checks on the ports of the snapshot control block.
`timescale 1ns/1ps
module ssc_snapshot_ctrl_checker
	import ssc_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     srst_in,
	// Register port
	input  wire logic [15:0]              reg_addr_in,
	input  wire logic [15:0]              reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	input  wire logic                     reg_rvalid_out,
	// Stream and signer
	input  wire logic [7:0]               hash_byte_out,
	input  wire logic                     hash_last_out,
	input  wire logic                     hash_valid_out,
	input  wire logic                     hash_ready_in,
	input  wire logic                     sign_start_out,
	input  wire logic                     sign_done_in,
	input  wire logic                     sign_err_in,
	// Device state
	input  wire logic [NUM_VALUES*32-1:0] meter_values_in,
	input  wire logic                     not_ready_out,
	input  wire logic [EVT_FAULT_W-1:0]   fault_flags_out,
	input  wire logic                     busy_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	wire logic [31:0] evt      = meter_values_in[EVT_VALUE_IDX*32 +: 32];
	wire logic        trig_cur = reg_wr_in && reg_addr_in == ADDR_CUR_STAT &&
		reg_wdata_in == STATUS_UPDATE && !busy_out;
	a_read_answer: assert property (reg_rd_in |-> ##2 reg_rvalid_out)
		else $error("read not answered two cycles later");
	a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in, 2))
		else $error("read data valid without a read");
	a_update_busy: assert property (trig_cur |=> busy_out ##1 busy_out)
		else $error("update write did not start a snapshot");
	a_stream_hold: assert property (hash_valid_out && !hash_ready_in |=> hash_valid_out &&
		$stable(hash_byte_out) && $stable(hash_last_out))
		else $error("stalled stream byte changed");
	a_sign_pulse: assert property (sign_start_out |=> !sign_start_out [*3])
		else $error("sign start longer than one pulse");
	a_done_idle: assert property (busy_out && (sign_done_in || sign_err_in) |=> !busy_out)
		else $error("sequence still busy after signer answered");
	a_not_ready: assert property (!$past(srst_in) |-> not_ready_out == ($past(evt) != 32'h0))
		else $error("not ready flag disagrees with event word");
	a_fault_bits: assert property (!$past(srst_in) |->
		fault_flags_out == $past(evt[EVT_FAULT_LSB +: EVT_FAULT_W]))
		else $error("fault flags disagree with event word");
	c_update: cover property (trig_cur ##1 busy_out);
	c_last: cover property (hash_last_out && hash_valid_out && hash_ready_in);
	c_stall: cover property (hash_valid_out && !hash_ready_in);
	c_sign_err: cover property (busy_out && sign_err_in);
endmodule

bind ssc_snapshot_ctrl ssc_snapshot_ctrl_checker u_chk (.clk_in, .srst_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rvalid_out, .hash_byte_out, .hash_last_out,
	.hash_valid_out, .hash_ready_in, .sign_start_out, .sign_done_in, .sign_err_in,
	.meter_values_in, .not_ready_out, .fault_flags_out, .busy_out);

// >>> ssc_far_model.sv
// Far-side model: signing engine, hash consumer, text source and contactor.
`timescale 1ns/1ps
module ssc_far_model
	import ssc_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	// Scenario controls
	input  wire logic              slow_in,
	input  wire logic              sign_fail_in,
	input  wire logic              fb_stuck_in,
	// Block side
	input  wire logic [1:0]        text_sel_in,
	input  wire logic [7:0]        text_idx_in,
	output logic      [7:0]        text_len_out,
	output logic      [7:0]        text_byte_out,
	output logic                   hash_ready_out,
	input  wire logic              sign_start_in,
	output logic                   sign_done_out,
	output logic                   sign_err_out,
	output logic      [15:0]       sig_len_out,
	output logic      [15:0]       key_len_out,
	output logic                   store_wr_out,
	output logic      [MEM_AW-1:0] store_addr_out,
	output logic      [15:0]       store_data_out,
	input  wire logic              contactor_close_in,
	output logic                   contactor_fb_out
);
	logic [5:0] cnt_reg;
	logic [7:0] lfsr_reg;
	logic [1:0] fb_reg;
	logic       key_done_reg;
	// The last metadata text is empty so the zero-count case is always streamed.
	assign text_len_out   = (text_sel_in == 2'h3) ? 8'h00 : {6'h00, text_sel_in} + 8'h02;
	assign text_byte_out  = 8'h41 + text_idx_in + {6'h00, text_sel_in};
	assign hash_ready_out = !(slow_in && lfsr_reg[0]);
	assign key_len_out    = 16'h005b;
	assign sig_len_out    = 16'h0047;
	// First key and signature words carry the leading DER bytes, high byte first.
	assign store_wr_out   = !key_done_reg || cnt_reg == 6'h02;
	assign store_addr_out = key_done_reg ? SIG_BASE : KEY_BASE;
	assign store_data_out = key_done_reg ? 16'h3045 : 16'h3059;
	assign sign_done_out  = cnt_reg == 6'h01 && !sign_fail_in;
	assign sign_err_out   = cnt_reg == 6'h01 && sign_fail_in;
	assign contactor_fb_out = fb_reg[1];
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_reg <= 6'h00;
			lfsr_reg <= 8'h5a;
			fb_reg <= 2'h0;
			key_done_reg <= 1'b0;
		end else begin
			key_done_reg <= 1'b1;
			lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
			fb_reg <= fb_stuck_in ? fb_reg : {fb_reg[0], contactor_close_in};
			if (sign_start_in)
				cnt_reg <= slow_in ? 6'h1e : 6'h04;
			else if (cnt_reg != 6'h00)
				cnt_reg <= cnt_reg - 6'h01;
		end
	end
endmodule

// >>> ssc_snapshot_ctrl_bench.sv
// Self-checking bench for the signed snapshot control block.
`timescale 1ns/1ps
module ssc_snapshot_ctrl_bench
	import ssc_pkg::*;
();
	logic                     clk_in = 1'b0;
	logic                     srst_in = 1'b1;
	logic [15:0]              reg_addr_in = 16'h0000;
	logic [15:0]              reg_wdata_in = 16'h0000;
	logic                     reg_wr_in = 1'b0;
	logic                     reg_rd_in = 1'b0;
	logic [NUM_VALUES*32-1:0] meter_values_in = '0;
	logic                     release_in = 1'b1;
	logic                     slow = 1'b0;
	logic                     fail = 1'b0;
	logic                     stuck = 1'b0;
	logic [15:0]              rdata, sig_len, key_len, sdata;
	logic [7:0]               tlen, tbyte, tidx, hbyte;
	logic [1:0]               tsel;
	logic [6:0]               saddr;
	logic [3:0]               flags;
	logic                     rvalid, hlast, hvalid, hready, sstart, sdone, serr, swr;
	logic                     fb, close, not_ready;
	int                       failures = 0;
	int                       compares = 0;
	int                       seed = 77;
	int                       response_counter = 0;
	logic [7:0]               exp_q[$], got_q[$];
	logic                     last_q[$];

	ssc_snapshot_ctrl #(.FB_WAIT_CYC(20)) dut (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.meter_values_in, .text_sel_out(tsel), .text_idx_out(tidx), .text_len_in(tlen),
		.text_byte_in(tbyte), .hash_byte_out(hbyte), .hash_last_out(hlast),
		.hash_valid_out(hvalid), .hash_ready_in(hready), .sign_start_out(sstart),
		.sign_done_in(sdone), .sign_err_in(serr), .sig_len_in(sig_len), .key_len_in(key_len),
		.store_wr_in(swr), .store_addr_in(saddr), .store_data_in(sdata),
		.charge_release_input_in(release_in), .contactor_fb_in(fb), .contactor_close_out(close),
		.not_ready_out(not_ready), .fault_flags_out(flags), .busy_out());
	ssc_far_model u_far (.clk_in, .srst_in, .slow_in(slow), .sign_fail_in(fail),
		.fb_stuck_in(stuck), .text_sel_in(tsel), .text_idx_in(tidx), .text_len_out(tlen),
		.text_byte_out(tbyte), .hash_ready_out(hready), .sign_start_in(sstart),
		.sign_done_out(sdone), .sign_err_out(serr), .sig_len_out(sig_len),
		.key_len_out(key_len), .store_wr_out(swr), .store_addr_out(saddr),
		.store_data_out(sdata), .contactor_close_in(close), .contactor_fb_out(fb));

	always #5 clk_in = ~clk_in;
	always @(negedge clk_in) begin
		if (hvalid && hready) begin
			got_q.push_back(hbyte);
			last_q.push_back(hlast);
		end
	end

	task automatic tally_and_finish();
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] want);
		compares++;
		if (got !== want) begin
			failures++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, got, want);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		int n;
		@(negedge clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge clk_in);
		reg_rd_in = 1'b0;
		for (n = 0; n < 4 && rvalid !== 1'b1; n++)
			@(negedge clk_in);
		if (n == 4) begin
			failures++;
			tally_and_finish();
		end
		d = rdata;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] want);
		logic [15:0] v;
		rd(a, v);
		check(v, want);
	endtask
	task automatic push_word(input logic [31:0] v);
		for (int i = 3; i >= 0; i--)
			exp_q.push_back(v[8*i +: 8]);
	endtask
	// Expected record: numbers as value, zero exponent, unit; texts as count then bytes.
	task automatic build(input logic [2:0] kind);
		logic [7:0] sel, len;
		exp_q.delete();
		for (int f = 0; f < NUM_FIELDS; f++) begin
			if (FIELD_TEXT[f]) begin
				sel = (f == F_ADDR_TEXT) ? 8'h00 : 8'(f - F_META_BASE);
				len = (sel == 8'h03) ? 8'h00 : sel + 8'h02;
				push_word({24'h0, len});
				for (int j = 0; j < len; j++)
					exp_q.push_back(8'h41 + 8'(j) + sel);
			end else begin
				push_word(f == F_TYPE ? {29'h0, kind} : f == F_RESPONSE_COUNTER ? 32'(response_counter) :
					meter_values_in[32*FIELD_SRC[f] +: 32]);
				exp_q.push_back(8'h00);
				exp_q.push_back(FIELD_UNIT[f]);
			end
		end
	endtask
	task automatic run(input logic [15:0] a, input logic [2:0] kind, input logic [15:0] want,
		input bit capt);
		logic [15:0] s;
		int n;
		for (n = 0; n < EVT_VALUE_IDX; n++)
			meter_values_in[32*n +: 32] = $random(seed);
		if (capt)
			response_counter++;
		build(kind);
		got_q.delete();
		last_q.delete();
		wr(a, STATUS_UPDATE);
		rd(a, s);
		if (want < 16'h0004)
			check(s, 16'(ST_UPDATING));
		for (n = 0; n < 600 && s === 16'h0002; n++)
			rd(a, s);
		for (n = (s === 16'h0002) ? 200 : 0; n < 200 && hvalid; n++)
			@(negedge clk_in);
		if (n == 200) begin
			failures++;
			tally_and_finish();
		end
		check(s, want);
		check(16'(got_q.size()), capt ? 16'(exp_q.size()) : 16'h0000);
		if (capt && got_q.size() == exp_q.size()) begin
			foreach (exp_q[i]) begin
				check({8'h00, got_q[i]}, {8'h00, exp_q[i]});
				check({15'h0, last_q[i]}, 16'(i == exp_q.size() - 1));
			end
		end
	endtask

	initial begin
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		srst_in = 1'b0;
		rd_chk(ADDR_CUR_STAT, 16'(ST_INVALID));
		rd_chk(ADDR_ON_STAT, 16'(ST_INVALID));
		rd_chk(ADDR_OFF_STAT, 16'(ST_INVALID));
		rd_chk(ADDR_KEY_AREA, AREA_WORDS);
		rd_chk(ADDR_KEY_DATA, 16'h3059);
		wr(ADDR_KEY_LEN, 16'h0002);
		wr(16'h1234, 16'h0002);
		wr(ADDR_CUR_STAT, 16'h0003);
		rd_chk(ADDR_KEY_LEN, 16'h005b);
		rd_chk(16'h1234, 16'h0000);
		rd_chk(ADDR_CUR_STAT, 16'(ST_INVALID));
		run(ADDR_CUR_STAT, KIND_CURRENT, 16'(ST_VALID), 1'b1);
		slow = 1'b1;
		run(ADDR_CUR_STAT, KIND_CURRENT, 16'(ST_VALID), 1'b1);
		slow = 1'b0;
		rd_chk(ADDR_SIG_AREA, AREA_WORDS);
		rd_chk(ADDR_SIG_LEN, 16'h0047);
		rd_chk(ADDR_SIG_DATA, 16'h3045);
		release_in = 1'b0;
		repeat (4) @(negedge clk_in);
		run(ADDR_ON_STAT, KIND_TURN_ON, 16'(ST_FAIL_RELEASE), 1'b0);
		check({15'h0, close}, 16'h0000);
		release_in = 1'b1;
		repeat (4) @(negedge clk_in);
		run(ADDR_ON_STAT, KIND_TURN_ON, 16'(ST_VALID), 1'b1);
		check({15'h0, close}, 16'h0001);
		stuck = 1'b1;
		run(ADDR_OFF_STAT, KIND_TURN_OFF, 16'(ST_FAIL_CONTACT), 1'b0);
		check({15'h0, close}, 16'h0000);
		stuck = 1'b0;
		repeat (4) @(negedge clk_in);
		run(ADDR_OFF_STAT, KIND_TURN_OFF, 16'(ST_VALID), 1'b1);
		fail = 1'b1;
		run(ADDR_CUR_STAT, KIND_CURRENT, 16'(ST_FAIL_GENERAL), 1'b1);
		fail = 1'b0;
		meter_values_in[EVT_VALUE_IDX*32 +: 32] = 32'h000a0000;
		repeat (3) @(negedge clk_in);
		check({15'h0, not_ready}, 16'h0001);
		check({12'h0, flags}, 16'h000a);
		meter_values_in[EVT_VALUE_IDX*32 +: 32] = 32'h00000000;
		repeat (3) @(negedge clk_in);
		check({15'h0, not_ready}, 16'h0000);
		tally_and_finish();
	end
endmodule
